// *** include/mph_pkg.sv ***
// Constants and types shared by both ends of the multiplexed memory bus.
// Assumes a single 50 MHz system clock for both ends.
package mph_pkg;
    localparam int ADQ_W = 16;
    localparam int UPA_W = 7;
    localparam int WADDR_W = 23;
    localparam int ROW_W = 7;
    localparam int MEM_AW = 8;
    // Configuration register select (upper address bits 19:18)
    localparam int CFG_SEL_LSB = 18;
    localparam logic [1:0] CFG_SEL_RCR = 2'h0;
    localparam logic [1:0] CFG_SEL_BCR = 2'h2;
    localparam logic [1:0] CFG_SEL_ID = 2'h1;
    localparam int BCR_MODE_BIT = 15;
    localparam int BCR_WRAP_BIT = 3;
    localparam int RCR_DPD_BIT = 4;
    localparam logic [15:0] BCR_RESET = 16'h9d1f;
    localparam logic [15:0] RCR_RESET = 16'h0010;
    // Identification value, arbitrary
    localparam logic [15:0] ID_VALUE = 16'h5a01;
    localparam int REFRESH_PERIOD_NS = 640;
    localparam int CLK_NS = 20;
    localparam int REFRESH_CYC = REFRESH_PERIOD_NS / CLK_NS;
    localparam logic [5:0] REFRESH_CYC_W = 6'(REFRESH_CYC);
    localparam logic [1:0] REFRESH_BUSY = 2'h2;
    typedef enum logic [1:0] {
        MPH_IDLE = 2'b00,
        MPH_ADDR = 2'b01,
        MPH_DATA = 2'b10,
        MPH_WAIT = 2'b11
    } mph_state_t;
endpackage : mph_pkg

// *** include/mph_bus_if.sv ***
// Pin bundle between the host controller and the memory.
// Resolves the shared bus from the two output enables.
`timescale 1ns/1ps
`default_nettype none
interface mph_bus_if;
    import mph_pkg::*;
    logic clk_link;
    logic addr_valid_n;
    logic chip_sel_n;
    logic out_en_n;
    logic write_en_n;
    logic cfg_reg_select;
    logic low_byte_en_n;
    logic high_byte_en_n;
    logic [UPA_W-1:0] upper_addr;
    logic [ADQ_W-1:0] adq_host_o;
    logic adq_host_oe;
    logic [ADQ_W-1:0] adq_mem_o;
    logic adq_mem_oe;
    logic wait_o;
    logic wait_oe;
    wire [ADQ_W-1:0] adq = adq_host_oe ? adq_host_o :
        (adq_mem_oe ? adq_mem_o : {ADQ_W{1'b0}});
    wire wait_lvl = wait_oe ? wait_o : 1'b0;
    modport host (
        output clk_link, addr_valid_n, chip_sel_n, out_en_n, write_en_n,
        output cfg_reg_select, low_byte_en_n, high_byte_en_n, upper_addr,
        output adq_host_o, adq_host_oe,
        input adq, wait_lvl, wait_oe
    );
    modport mem (
        input clk_link, addr_valid_n, chip_sel_n, out_en_n, write_en_n,
        input cfg_reg_select, low_byte_en_n, high_byte_en_n, upper_addr,
        input adq,
        output adq_mem_o, adq_mem_oe, wait_o, wait_oe
    );
endinterface : mph_bus_if
`default_nettype wire

// *** src/mph_lane_mask.sv ***
// Per-byte write merge for a 16-bit word.
// Pure combinational; byte enables active low.
`timescale 1ns/1ps
`default_nettype none
module mph_lane_mask
    import mph_pkg::*;
(
    input wire logic [ADQ_W-1:0] old_word,
    input wire logic [ADQ_W-1:0] new_word,
    input wire logic low_byte_en_n,
    input wire logic high_byte_en_n,
    output logic [ADQ_W-1:0] merged
);
    wire [1:0] lane_n = {high_byte_en_n, low_byte_en_n};
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_lane
            assign merged[g*8 +: 8] = lane_n[g] ? old_word[g*8 +: 8] :
                new_word[g*8 +: 8];
        end
    endgenerate
endmodule : mph_lane_mask
`default_nettype wire

// *** src/mph_mem.sv ***
// Memory end of the multiplexed bus: address capture, config registers,
// byte-lane writes, WAIT generation and deep sleep.
// Assumes pins are synchronous to clk_sys; link clock sampled for edges.
// How it works
// - Burst mode: capture address at first clock rise
// - Host holds clock static during async access
// - Async mode: capture address when strobe rises
// - Register select routes access to config registers
// - Chip select high puts memory in standby
// - Drive bus only while output enable low
// - Write enable low means write cycle
// - Byte enables gate low and high bytes
// - Bus carries address while strobe low, else data
// - Captured address is a word address
// - Upper address captured, bits 19:18 select the config register
// - WAIT flags data valid and refresh stalls
// - WAIT at row end unless wrapping
// - WAIT released when chip select high
// - Host ignores WAIT in async accesses
// - Async-only host may tie clock
// - Mode bit selects async or burst
// - Burst: write enable at capture picks direction
// - Deep sleep from select rise after bit cleared
`timescale 1ns/1ps
`default_nettype none
module mph_mem
    import mph_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clk_en,
    mph_bus_if.mem bus,
    output logic [WADDR_W-1:0] last_addr,
    output logic deep_sleep_mode,
    output logic standby,
    output logic burst_mode
);
    logic [ADQ_W-1:0] mem_q [0:(1<<MEM_AW)-1];
    logic [ADQ_W-1:0] bcr_q;
    logic [ADQ_W-1:0] rcr_q;
    logic [WADDR_W-1:0] addr_q;
    logic [ADQ_W-1:0] rdata_q;
    logic clk_link_q;
    logic adv_n_q;
    logic cs_n_q;
    logic is_write_q;
    logic is_cfg_q;
    logic dpd_q;
    logic [5:0] ref_cnt_q;
    logic [1:0] ref_busy_q;
    logic [ADQ_W-1:0] adq_q;
    logic [WADDR_W-1:0] start_q;
    logic is_sync_q;
    logic cross_q;
    mph_state_t state_q;
    logic [ADQ_W-1:0] merged;

    // Decode of the pin levels
    wire sel = !bus.chip_sel_n && !dpd_q;
    wire sync_mode = !bcr_q[BCR_MODE_BIT];
    wire clk_rise = bus.clk_link && !clk_link_q;
    wire adv_rise = bus.addr_valid_n && !adv_n_q;
    wire cap_sync = sel && sync_mode && !bus.addr_valid_n && clk_rise
        && state_q == MPH_IDLE;
    // Async capture also serves plain accesses while burst mode is set
    wire cap_async = sel && adv_rise && state_q == MPH_IDLE;
    wire capture = cap_sync || cap_async;
    // At the strobe rise the bus already carries data: use the held value
    wire [ADQ_W-1:0] cap_low = cap_async ? adq_q : bus.adq;
    wire [WADDR_W-1:0] cap_addr = {bus.upper_addr, cap_low};
    wire [MEM_AW-1:0] mem_idx = addr_q[MEM_AW-1:0];
    wire data_phase = sel && bus.addr_valid_n && state_q != MPH_IDLE;
    wire [1:0] cfg_sel = addr_q[CFG_SEL_LSB +: 2];
    wire row_end = &addr_q[ROW_W-1:0];
    wire wrap_on = bcr_q[BCR_WRAP_BIT];
    wire burst_step = is_sync_q && clk_rise && state_q == MPH_DATA;
    wire async_wr_strobe = !is_sync_q && data_phase && !bus.write_en_n;
    // A stalled clock edge moves no word; the host sees WAIT and retries
    wire wait_now = is_sync_q && state_q == MPH_DATA
        && (ref_busy_q != 2'h0 || cross_q);
    wire step_ok = burst_step && !wait_now;
    wire sync_wr_strobe = step_ok && is_write_q;
    wire wr_strobe = async_wr_strobe || sync_wr_strobe;
    wire cfg_write = capture && bus.cfg_reg_select && !bus.write_en_n;
    wire refresh_hit = ref_cnt_q == REFRESH_CYC_W - 6'h1;
    wire dpd_entry = !cs_n_q && bus.chip_sel_n && !rcr_q[RCR_DPD_BIT];

    function automatic logic [ADQ_W-1:0] cfg_read(input logic [1:0] s,
        input logic [ADQ_W-1:0] b, input logic [ADQ_W-1:0] r);
        cfg_read = (s == CFG_SEL_BCR) ? b : (s == CFG_SEL_RCR) ? r : ID_VALUE;
    endfunction : cfg_read

    mph_lane_mask u_lane (
        .old_word(mem_q[mem_idx]),
        .new_word(bus.adq),
        .low_byte_en_n(bus.low_byte_en_n),
        .high_byte_en_n(bus.high_byte_en_n),
        .merged(merged)
    );

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            clk_link_q <= 1'b0;
            adv_n_q <= 1'b1;
            cs_n_q <= 1'b1;
            adq_q <= '0;
        end else if (clk_en) begin
            clk_link_q <= bus.clk_link;
            adv_n_q <= bus.addr_valid_n;
            cs_n_q <= bus.chip_sel_n;
            if (!bus.addr_valid_n) begin
                adq_q <= bus.adq;
            end
        end
    end

    // Access state and captured address
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q <= MPH_IDLE;
            addr_q <= '0;
            start_q <= '0;
            is_write_q <= 1'b0;
            is_cfg_q <= 1'b0;
            is_sync_q <= 1'b0;
        end else if (clk_en) begin
            if (!sel) begin
                state_q <= MPH_IDLE;
            end else if (capture) begin
                // Burst capture waits in ADDR until the strobe goes high
                state_q <= cap_sync ? MPH_ADDR : MPH_DATA;
                addr_q <= cap_addr;
                start_q <= cap_addr;
                is_write_q <= !bus.write_en_n;
                is_cfg_q <= bus.cfg_reg_select;
                is_sync_q <= cap_sync;
            end else if (state_q == MPH_ADDR && bus.addr_valid_n) begin
                state_q <= MPH_DATA;
            end else if (step_ok && !is_cfg_q) begin
                addr_q[ROW_W-1:0] <= addr_q[ROW_W-1:0] + 7'h1;
            end
        end
    end

    // Configuration registers and deep sleep
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bcr_q <= BCR_RESET;
            rcr_q <= RCR_RESET;
            dpd_q <= 1'b0;
        end else if (clk_en) begin
            if (cfg_write && cap_addr[CFG_SEL_LSB +: 2] == CFG_SEL_BCR) begin
                bcr_q <= cap_low;
            end
            if (cfg_write && cap_addr[CFG_SEL_LSB +: 2] == CFG_SEL_RCR) begin
                rcr_q <= cap_low;
            end
            if (dpd_entry) begin
                dpd_q <= 1'b1;
            end else if (cs_n_q && !bus.chip_sel_n) begin
                dpd_q <= 1'b0;
                rcr_q[RCR_DPD_BIT] <= 1'b1;
            end
        end
    end

    // Row crossing stalls one clock edge when the burst does not wrap
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cross_q <= 1'b0;
        end else if (clk_en) begin
            if (!sel || capture) begin
                cross_q <= 1'b0;
            end else if (step_ok && !is_cfg_q && row_end && !wrap_on) begin
                cross_q <= 1'b1;
            end else if (burst_step) begin
                cross_q <= 1'b0;
            end
        end
    end

    // Array write with byte lanes
    always_ff @(posedge clk_sys) begin
        if (clk_en && wr_strobe && !is_cfg_q) begin
            mem_q[mem_idx] <= merged;
        end
    end

    // Read data, hidden refresh and WAIT
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdata_q <= '0;
            ref_cnt_q <= '0;
            ref_busy_q <= '0;
        end else if (clk_en) begin
            rdata_q <= is_cfg_q ? cfg_read(cfg_sel, bcr_q, rcr_q) :
                mem_q[mem_idx];
            ref_cnt_q <= refresh_hit ? 6'h0 : ref_cnt_q + 6'h1;
            if (refresh_hit) begin
                ref_busy_q <= REFRESH_BUSY;
            end else if (ref_busy_q != 2'h0 && (!sync_mode || clk_rise)) begin
                ref_busy_q <= ref_busy_q - 2'h1;
            end
        end
    end

    assign bus.adq_mem_o = rdata_q;
    assign bus.adq_mem_oe = data_phase && !bus.out_en_n
        && bus.write_en_n && !is_write_q;
    assign bus.wait_o = wait_now;
    assign bus.wait_oe = !bus.chip_sel_n;
    assign last_addr = start_q;
    assign deep_sleep_mode = dpd_q;
    assign standby = !sel;
    assign burst_mode = sync_mode;
endmodule : mph_mem
`default_nettype wire

// *** src/mph_host.sv ***
// Host controller end: runs one access per request on the shared bus.
// Assumes the memory end on the same clk_sys.
`timescale 1ns/1ps
`default_nettype none
module mph_host
    import mph_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clk_en,
    mph_bus_if.host bus,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic req_cfg,
    input wire logic req_burst,
    input wire logic [1:0] req_byte_en_n,
    input wire logic [WADDR_W-1:0] req_addr,
    input wire logic [ADQ_W-1:0] req_wdata,
    output logic rsp_valid,
    output logic [ADQ_W-1:0] rsp_rdata
);
    mph_state_t state_q;
    logic [2:0] cnt_q;
    logic clk_q;
    logic wr_q;
    logic cfg_q;
    logic burst_q;
    logic [1:0] be_q;
    logic [WADDR_W-1:0] addr_q;
    logic [ADQ_W-1:0] wdata_q;
    logic rsp_valid_q;
    logic [ADQ_W-1:0] rdata_q;
    wire idle = state_q == MPH_IDLE;
    wire take = req_valid && idle;
    // Burst: one word, taken at the first link clock rise without WAIT
    wire done = state_q == MPH_DATA && (burst_q ?
        (clk_q && !bus.wait_lvl) : cnt_q == 3'h3);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q <= MPH_IDLE;
            cnt_q <= '0;
            clk_q <= 1'b0;
            wr_q <= 1'b0;
            cfg_q <= 1'b0;
            burst_q <= 1'b0;
            be_q <= 2'h3;
            addr_q <= '0;
            wdata_q <= '0;
            rsp_valid_q <= 1'b0;
            rdata_q <= '0;
        end else if (clk_en) begin
            rsp_valid_q <= 1'b0;
            // Link clock toggles only during burst accesses
            clk_q <= (burst_q && !idle) ? !clk_q : 1'b0;
            cnt_q <= (idle || cnt_q == 3'h3) ? 3'h0 : cnt_q + 3'h1;
            unique case (state_q)
                MPH_IDLE: begin
                    if (take) begin
                        state_q <= MPH_ADDR;
                        wr_q <= req_write;
                        cfg_q <= req_cfg;
                        burst_q <= req_burst;
                        be_q <= req_byte_en_n;
                        addr_q <= req_addr;
                        wdata_q <= req_wdata;
                    end
                end
                MPH_ADDR: begin
                    if (cnt_q == 3'h3) begin
                        state_q <= MPH_DATA;
                    end
                end
                MPH_DATA: begin
                    if (done) begin
                        state_q <= MPH_WAIT;
                        rsp_valid_q <= !wr_q;
                        rdata_q <= bus.adq;
                    end
                end
                MPH_WAIT: begin
                    state_q <= MPH_IDLE;
                end
            endcase
        end
    end

    wire addr_ph = state_q == MPH_ADDR;
    wire data_ph = state_q == MPH_DATA;
    assign bus.clk_link = clk_q;
    assign bus.chip_sel_n = !(addr_ph || data_ph);
    assign bus.addr_valid_n = !addr_ph;
    assign bus.write_en_n = !(wr_q && (addr_ph || data_ph));
    assign bus.out_en_n = !(data_ph && !wr_q);
    assign bus.cfg_reg_select = cfg_q && !idle;
    assign bus.low_byte_en_n = be_q[0];
    assign bus.high_byte_en_n = be_q[1];
    assign bus.upper_addr = addr_q[WADDR_W-1:ADQ_W];
    assign bus.adq_host_o = addr_ph ? addr_q[ADQ_W-1:0] : wdata_q;
    assign bus.adq_host_oe = addr_ph || (data_ph && wr_q && !cfg_q);
    assign req_ready = idle;
    assign rsp_valid = rsp_valid_q;
    assign rsp_rdata = rdata_q;
endmodule : mph_host
`default_nettype wire

// *** test/mph_pin_checker.sv ***
// Assertions on the pins joining the host end and the memory end.
// Assumes one clk_sys domain; instantiated beside the bus interface.
`timescale 1ns/1ps
`default_nettype none
module mph_pin_checker (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic addr_valid_n,
    input wire logic chip_sel_n,
    input wire logic out_en_n,
    input wire logic write_en_n,
    input wire logic cfg_reg_select,
    input wire logic adq_host_oe,
    input wire logic adq_mem_oe,
    input wire logic wait_o,
    input wire logic wait_oe
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_mem_drive_oe: assert property (adq_mem_oe |-> !out_en_n)
        else $error("memory drives bus with output enable high");
    a_mem_drive_cs: assert property (adq_mem_oe |-> !chip_sel_n)
        else $error("memory drives bus while deselected");
    a_wait_high_z: assert property (chip_sel_n |-> !wait_oe)
        else $error("wait driven while deselected");
    a_no_bus_clash: assert property (!(adq_host_oe && adq_mem_oe))
        else $error("both ends drive the shared bus");
    a_mem_data_only: assert property (!addr_valid_n |-> !adq_mem_oe)
        else $error("memory drives bus in address phase");
    a_addr_phase_len: assert property ($fell(addr_valid_n) |->
        (!addr_valid_n && adq_host_oe && !chip_sel_n)[*4] ##1 addr_valid_n)
        else $error("address phase malformed");
    a_write_no_drive: assert property (!write_en_n |-> !adq_mem_oe)
        else $error("memory drives bus during write");
    a_addr_oe_high: assert property (!addr_valid_n |-> out_en_n)
        else $error("output enable low during address phase");
    c_mem_read: cover property (adq_mem_oe);
    c_cfg_access: cover property (!addr_valid_n && cfg_reg_select);
    c_wait_seen: cover property (wait_oe && wait_o);
    c_write: cover property (!chip_sel_n && !write_en_n);
endmodule : mph_pin_checker
`default_nettype wire

// *** test/testbench.sv ***
// Self-checking bench: host end and memory end joined by the bus bundle.
// Assumes the shared package; random data from a fixed-seed shift register.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import mph_pkg::*;
    logic clk_sys, rst, req_valid, req_ready, req_write, req_cfg, req_burst;
    logic rsp_valid, deep_sleep_mode, standby, burst_mode;
    logic [1:0] req_byte_en_n;
    logic [WADDR_W-1:0] req_addr, last_addr;
    logic [ADQ_W-1:0] req_wdata, rsp_rdata, q, d1, d2, r;
    int fails, compares;
    mph_bus_if bus ();
    mph_host mph_host_inst (.clk_sys(clk_sys), .rst(rst), .clk_en(1'b1),
        .bus(bus), .req_valid(req_valid), .req_ready(req_ready),
        .req_write(req_write), .req_cfg(req_cfg), .req_burst(req_burst),
        .req_byte_en_n(req_byte_en_n), .req_addr(req_addr),
        .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
    mph_mem mph_mem_inst (.clk_sys(clk_sys), .rst(rst), .clk_en(1'b1),
        .bus(bus), .last_addr(last_addr), .deep_sleep_mode(deep_sleep_mode),
        .standby(standby), .burst_mode(burst_mode));
    mph_pin_checker mph_pin_checker_inst (.clk_sys(clk_sys), .rst(rst),
        .addr_valid_n(bus.addr_valid_n), .chip_sel_n(bus.chip_sel_n),
        .out_en_n(bus.out_en_n), .write_en_n(bus.write_en_n),
        .cfg_reg_select(bus.cfg_reg_select), .adq_host_oe(bus.adq_host_oe),
        .adq_mem_oe(bus.adq_mem_oe), .wait_o(bus.wait_o),
        .wait_oe(bus.wait_oe));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    function automatic logic [15:0] merge(input logic [15:0] o, n,
        input logic [1:0] be);
        return {be[1] ? o[15:8] : n[15:8], be[0] ? o[7:0] : n[7:0]};
    endfunction : merge
    task automatic test_done;
        $display("fails=%0d compares=%0d", fails, compares);
        if (fails == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] got, exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wait_ready;
        int n;
        n = 0;
        while (req_ready !== 1'b1) begin
            @(posedge clk_sys);
            #1;
            n++;
            if (n > 300) begin
                fails++;
                test_done();
            end
        end
    endtask : wait_ready
    task automatic acc(input logic w, c, b, input logic [1:0] be,
        input logic [22:0] a, input logic [15:0] d, output logic [15:0] rd);
        int n;
        rd = '0;
        wait_ready();
        {req_write, req_cfg, req_burst, req_byte_en_n} = {w, c, b, be};
        req_addr = a;
        req_wdata = d;
        req_valid = 1'b1;
        @(posedge clk_sys);
        #1;
        req_valid = 1'b0;
        n = 0;
        while (!w && rsp_valid !== 1'b1) begin
            @(posedge clk_sys);
            #1;
            n++;
            if (n > 300) begin
                fails++;
                test_done();
            end
        end
        rd = rsp_rdata;
        wait_ready();
    endtask : acc
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    initial begin
        {rst, req_valid, req_write, req_cfg, req_burst} = 5'h10;
        req_byte_en_n = 2'h0;
        req_addr = '0;
        req_wdata = '0;
        fails = 0;
        compares = 0;
        r = 16'hd0c4;
        repeat (16) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        chk(burst_mode, 1'b0);
        chk(standby, 1'b1);
        acc(0, 1, 0, 2'h0, 23'h040000, 16'h0000, q);
        chk(q, ID_VALUE);
        acc(0, 1, 0, 2'h0, 23'h080000, 16'h0000, q);
        chk(q, BCR_RESET);
        acc(0, 1, 0, 2'h0, 23'h000000, 16'h0000, q);
        chk(q, RCR_RESET);
        for (int i = 0; i < 16; i++) begin
            if (i == 12) begin
                acc(1, 1, 0, 2'h0, 23'h081d17, 16'h0000, q);
                chk(burst_mode, 1'b1);
            end
            r = lfsr(r);
            d1 = r;
            r = lfsr(r);
            d2 = r;
            req_addr = {r[6:0], lfsr(r)};
            if (i == 15) begin
                req_addr[6:0] = 7'h7f;
            end
            acc(1, 0, i >= 12, 2'h0, req_addr, d1, q);
            acc(1, 0, i >= 12, r[1:0], req_addr, d2, q);
            acc(0, 0, i >= 12, 2'h0, req_addr, 16'h0000, q);
            chk(q, merge(d1, d2, r[1:0]));
            chk(last_addr, {9'h0, req_addr});
        end
        acc(1, 1, 0, 2'h0, 23'h000000, 16'h0000, q);
        chk(deep_sleep_mode, 1'b1);
        acc(0, 0, 0, 2'h0, 23'h000005, 16'h0000, q);
        chk(deep_sleep_mode, 1'b0);
        acc(0, 1, 0, 2'h0, 23'h000000, 16'h0000, q);
        chk(q, RCR_RESET);
        test_done();
    end
endmodule : testbench
`default_nettype wire
